//--- core/bmrd_decode.sv
// bmrd_decode: address-zero boot/remap decoder for two bus masters.
// assumes masters and erase/remap pulses run on mclk; the nv bit pin is async.
module bmrd_decode
  import bmrd_pkg::*;
(
  input  wire logic                 mclk,               // matrix clock
  input  wire logic                 rstn,               // async reset, low
  input  wire logic                 boot_source_nv_bit, // nv boot-select pin
  input  wire logic                 flash_full_erase,   // erase pulse
  input  wire logic                 remap_set,          // sw remap set pulse
  input  wire logic                 remap_clr,          // sw remap clear pulse
  input  wire logic [BMRD_NMST-1:0] m_valid,            // master request
  input  wire logic [BMRD_AW-1:0]   m_addr [BMRD_NMST], // master addresses
  output logic      [3:0]           m_sel  [BMRD_NMST], // one-hot slave pick
  output logic      [BMRD_NMST-1:0] m_abort,            // abort answer
  output logic                      boot_source_select, // captured boot bit
  output logic                      remap               // remap state
);
  import bmrd_pkg::*;

  // synchroniser for the nv pin
  logic nv_s1, nv_s2;                 // two-stage sync
  logic nv_eff;                       // nv value after erase forcing
  logic erased;                       // erase seen since reset
  logic captured;                     // capture done flag
  logic fill_s1;                      // sync stage 1 holds pin data
  logic fill_s2;                      // sync stage 2 holds pin data
  logic next_erased, next_captured, next_boot, next_remap;

  // next-state for boot capture and remap
  always_comb begin
    next_erased   = erased | flash_full_erase;
    nv_eff        = nv_s2 & ~erased & ~flash_full_erase;
    // capture once, when the sync stage holds real pin data; the sync
    // flops reset to zero, so taking them earlier would always pick rom
    next_captured = captured | fill_s2;
    next_boot     = (fill_s2 && !captured) ? nv_eff
                                           : boot_source_select;
    next_remap    = remap;
    if (remap_set) begin
      next_remap = 1'b1;
    end else if (remap_clr) begin
      next_remap = 1'b0;
    end
  end

  // state registers; remap and boot start cleared
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nv_s1              <= 1'b0;
      nv_s2              <= 1'b0;
      erased             <= 1'b0;
      captured           <= 1'b0;
      fill_s1            <= 1'b0;
      fill_s2            <= 1'b0;
      boot_source_select <= BMRD_BOOT_RST;
      remap              <= BMRD_REMAP_RST;
    end else begin
      nv_s1              <= boot_source_nv_bit;
      nv_s2              <= nv_s1;
      erased             <= next_erased;
      captured           <= next_captured;
      fill_s1            <= 1'b1;
      fill_s2            <= fill_s1;
      boot_source_select <= next_boot;
      remap              <= next_remap;
    end
  end
  // capture lands on the third edge after release: two edges to fill
  // the sync, one to take it; requests before then see the rom choice,
  // so masters must hold off until captured is high (cpu reset is longer)

  // per-master decoders, identical boot arrangement for each
  genvar g;
  generate
    for (g = 0; g < BMRD_NMST; g++) begin : g_mst
      logic [3:0] next_sel;   // decoded slave
      logic       next_abt;   // decoded abort
      always_comb begin
        next_sel = 4'h0;
        next_abt = 1'b0;
        if (m_valid[g]) begin
          if (m_addr[g][31:28] == BMRD_REG_BOOT) begin
            // three candidates at zero, chosen by remap then boot bit
            if (remap) begin
              next_sel = BMRD_SEL_SRAM;
            end else if (boot_source_select) begin
              next_sel = BMRD_SEL_FLASH;
            end else begin
              next_sel = BMRD_SEL_ROM;
            end
          end else if (m_addr[g][31:28] == BMRD_REG_INTM) begin
            // fixed bases, independent of remap and boot bit
            case (m_addr[g][27:20])
              BMRD_BASE_ROM:   next_sel = BMRD_SEL_ROM;
              BMRD_BASE_SRAM:  next_sel = BMRD_SEL_SRAM;
              BMRD_BASE_FLASH: next_sel = BMRD_SEL_FLASH;
              default: begin
                next_sel = BMRD_SEL_ABORT;
                next_abt = 1'b1;
              end
            endcase
          end else begin
            next_sel = BMRD_SEL_ABORT;
            next_abt = 1'b1;
          end
        end
      end
      // registered outputs, one cycle after the request
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          m_sel[g]   <= 4'h0;
          m_abort[g] <= 1'b0;
        end else begin
          m_sel[g]   <= next_sel;
          m_abort[g] <= next_abt;
        end
      end

      // zero address goes to remap/boot choice one cycle later
      property p_zero_map;
        @(posedge mclk) disable iff (!rstn)
        (m_valid[g] && m_addr[g][31:28] == BMRD_REG_BOOT)
        |=> m_sel[g] == ($past(remap) ? BMRD_SEL_SRAM :
                         $past(boot_source_select) ? BMRD_SEL_FLASH :
                         BMRD_SEL_ROM);
      endproperty
      a_zero_map: assert property (p_zero_map)
        else $error("wrong slave at boot window");

      property p_abort;
        @(posedge mclk) disable iff (!rstn)
        (m_valid[g] && m_addr[g][31:29] != 3'h0)
        |=> m_abort[g] && m_sel[g] == BMRD_SEL_ABORT;
      endproperty
      a_abort: assert property (p_abort)
        else $error("unused area not aborted");

      property p_fixed_sram;
        @(posedge mclk) disable iff (!rstn)
        (m_valid[g] && m_addr[g][31:20] == {BMRD_REG_INTM, BMRD_BASE_SRAM})
        |=> m_sel[g] == BMRD_SEL_SRAM && !m_abort[g];
      endproperty
      a_fixed_sram: assert property (p_fixed_sram)
        else $error("sram lost its own base");

      property p_idle;
        @(posedge mclk) disable iff (!rstn)
        !m_valid[g] |=> m_sel[g] == 4'h0 && !m_abort[g];
      endproperty
      a_idle: assert property (p_idle)
        else $error("select without request");
    end
  endgenerate

  property p_same_map;
    @(posedge mclk) disable iff (!rstn)
    (m_valid == 2'b11 && m_addr[0][31:28] == BMRD_REG_BOOT &&
     m_addr[1][31:28] == BMRD_REG_BOOT) |=> m_sel[0] == m_sel[1];
  endproperty
  a_same_map: assert property (p_same_map)
    else $error("masters see different boot map");

  property p_boot_hold;
    @(posedge mclk) disable iff (!rstn)
    captured |=> $stable(boot_source_select);
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("boot choice changed after capture");

  // strap level is taken from the filled sync stage unless erased
  property p_capture;
    @(posedge mclk) disable iff (!rstn)
    (fill_s2 && !captured && !erased && !flash_full_erase)
    |=> boot_source_select == $past(nv_s2);
  endproperty
  a_capture: assert property (p_capture)
    else $error("boot choice not taken from strap");

  property p_erase;
    @(posedge mclk) disable iff (!rstn)
    (flash_full_erase && !captured) |=> !boot_source_select;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase did not clear boot bit");

  sequence s_set;
    remap_set;
  endsequence
  property p_remap;
    @(posedge mclk) disable iff (!rstn)
    s_set |=> remap;
  endproperty
  a_remap: assert property (p_remap)
    else $error("remap not taken");

  property p_remap_rst;
    @(posedge mclk) disable iff (!rstn)
    $rose(rstn) |-> !remap;
  endproperty
  a_remap_rst: assert property (p_remap_rst)
    else $error("remap not cleared at reset");

  property p_rom_boot;
    @(posedge mclk) disable iff (!rstn)
    (!remap && !boot_source_select && m_valid[0] &&
     m_addr[0][31:28] == BMRD_REG_BOOT) |=> m_sel[0] == BMRD_SEL_ROM;
  endproperty
  a_rom_boot: assert property (p_rom_boot)
    else $error("rom not at zero");

  property p_flash_boot;
    @(posedge mclk) disable iff (!rstn)
    (!remap && boot_source_select && m_valid[1] &&
     m_addr[1][31:28] == BMRD_REG_BOOT) |=> m_sel[1] == BMRD_SEL_FLASH;
  endproperty
  a_flash_boot: assert property (p_flash_boot)
    else $error("flash not at zero");

  property p_window;
    @(posedge mclk) disable iff (!rstn)
    (m_valid[0] && m_addr[0][31:28] == BMRD_REG_BOOT) |=> !m_abort[0];
  endproperty
  a_window: assert property (p_window)
    else $error("boot window aborted");
endmodule

//--- core/bmrd_pkg.sv
// bmrd_pkg: constants and types shared by the boot memory remap decoder.
// assumes a 32-bit byte address from each bus master.
package bmrd_pkg;
  localparam int unsigned BMRD_NMST   = 2;            // instr and data masters
  localparam int unsigned BMRD_AW     = 32;           // address width
  // top nibble picks a 256 MB region
  localparam logic [3:0]  BMRD_REG_BOOT  = 4'h0;      // boot window
  localparam logic [3:0]  BMRD_REG_INTM  = 4'h1;      // own bases region
  // own bases inside region 1 (bits 27:20)
  localparam logic [7:0]  BMRD_BASE_ROM   = 8'h00;    // rom at 0x1000_0000
  localparam logic [7:0]  BMRD_BASE_SRAM  = 8'h01;    // sram at 0x1010_0000
  localparam logic [7:0]  BMRD_BASE_FLASH = 8'h02;    // flash at 0x1020_0000
  localparam logic        BMRD_REMAP_RST = 1'b0;      // remap reset value
  localparam logic        BMRD_BOOT_RST  = 1'b0;      // rom boot at reset
  // slave select, one-hot
  typedef enum logic [3:0] {
    BMRD_SEL_ROM   = 4'h1,
    BMRD_SEL_FLASH = 4'h2,
    BMRD_SEL_SRAM  = 4'h4,
    BMRD_SEL_ABORT = 4'h8
  } bmrd_sel_e;
endpackage

//--- bench/bmrd_mst_model.sv
// bmrd_mst_model: instr and data bus masters facing the decoder.
// assumes free-running mclk; each request held for exactly one edge.
module bmrd_mst_model (
  input  wire logic                          mclk,    // matrix clock
  output logic [bmrd_pkg::BMRD_NMST-1:0]     m_valid, // requests
  output logic [bmrd_pkg::BMRD_AW-1:0]       m_addr [bmrd_pkg::BMRD_NMST],
  input  wire logic [3:0]                    m_sel [bmrd_pkg::BMRD_NMST],
  input  wire logic [bmrd_pkg::BMRD_NMST-1:0] m_abort  // abort answer
);
  timeunit 1ns;
  timeprecision 1ps;
  import bmrd_pkg::*;
  initial begin
    m_valid = '0;
    m_addr  = '{default: '0};
  end
  // both masters at once, each with its own address
  task automatic acc(input logic [31:0] a0, input logic [31:0] a1,
                     output logic [3:0] s0, output logic [3:0] s1,
                     output logic [1:0] ab);
    @(posedge mclk);
    #2;
    m_valid   = '1;
    m_addr[0] = a0;
    m_addr[1] = a1;
    @(posedge mclk);
    #2;
    // answer stands one cycle, take it now
    s0 = m_sel[0];
    s1 = m_sel[1];
    ab = m_abort;
    // released bus shows the inverse, not a stale copy
    m_valid   = '0;
    m_addr[0] = ~a0;
    m_addr[1] = ~a1;
  endtask
endmodule

//--- bench/tb_boot_memory_remap_decode.sv
// tb_boot_memory_remap_decode: self-checking bench of the boot decoder.
// assumes the master model answers with the one-cycle decode latency.
module tb_boot_memory_remap_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import bmrd_pkg::*;
  logic mclk = 0, rstn = 0, nv = 0, er = 0, rs = 0, rc = 0;
  logic [BMRD_NMST-1:0] m_valid, m_abort;
  logic [BMRD_AW-1:0]   m_addr [BMRD_NMST];
  logic [3:0]           m_sel  [BMRD_NMST];
  logic                 bss, remap;
  int err_total = 0, n_checks = 0;
  always #12.5 mclk = ~mclk;
  bmrd_decode DUT (.mclk(mclk), .rstn(rstn), .boot_source_nv_bit(nv),
    .flash_full_erase(er), .remap_set(rs), .remap_clr(rc),
    .m_valid(m_valid), .m_addr(m_addr), .m_sel(m_sel), .m_abort(m_abort),
    .boot_source_select(bss), .remap(remap));
  bmrd_mst_model mst (.mclk(mclk), .m_valid(m_valid), .m_addr(m_addr),
    .m_sel(m_sel), .m_abort(m_abort));
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one access per master, both answers and abort flags judged
  task automatic pick(input logic [31:0] a0, input logic [3:0] e0,
                      input logic [31:0] a1, input logic [3:0] e1);
    logic [3:0] s0, s1;
    logic [1:0] ab;
    mst.acc(a0, a1, s0, s1, ab);
    chk(s0, e0);
    chk(s1, e1);
    chk({2'h0, ab}, {2'h0, e1 == BMRD_SEL_ABORT, e0 == BMRD_SEL_ABORT});
  endtask
  // reset with a strap level; erase may ride the release edge
  task automatic do_reset(input logic lvl, input logic ers);
    @(posedge mclk);
    #2 rstn = 0;
    nv = lvl;
    repeat (16) @(posedge mclk);
    #2 rstn = 1;
    er = ers;
    @(posedge mclk);
    #2 er = 0;
    // third edge after release takes the strap; look one edge later
    repeat (3) @(posedge mclk);
    #2;
  endtask
  task automatic remap_pulse(input logic on);
    @(posedge mclk);
    #2 {rs, rc} = {on, !on};
    @(posedge mclk);
    #2 {rs, rc} = 2'b00;
  endtask
  task automatic t_rom_boot();
    chk({3'h0, remap}, 4'h0);
    chk({3'h0, bss}, 4'h0);
    pick(32'h0, BMRD_SEL_ROM, 32'h0fff_fffc, BMRD_SEL_ROM);
    pick(32'h0800_0000, BMRD_SEL_ROM, 32'h0, BMRD_SEL_ROM);
    $display("test rom_boot done");
  endtask
  task automatic t_own_bases();
    pick(32'h1000_0000, BMRD_SEL_ROM, 32'h1010_0000, BMRD_SEL_SRAM);
    pick(32'h1020_0000, BMRD_SEL_FLASH, 32'h1030_0000, BMRD_SEL_ABORT);
    pick(32'h2000_0000, BMRD_SEL_ABORT, 32'hffff_0000, BMRD_SEL_ABORT);
    $display("test own_bases done");
  endtask
  task automatic t_late_strap();
    @(posedge mclk);
    #2 nv = 1; // strap moves only after capture
    repeat (4) @(posedge mclk);
    #2 chk({3'h0, bss}, 4'h0);
    pick(32'h0, BMRD_SEL_ROM, 32'h0, BMRD_SEL_ROM);
    $display("test late_strap done");
  endtask
  task automatic t_remap();
    remap_pulse(1);
    chk({3'h0, remap}, 4'h1);
    pick(32'h0, BMRD_SEL_SRAM, 32'h0fff_fffc, BMRD_SEL_SRAM);
    pick(32'h1000_0000, BMRD_SEL_ROM, 32'h1020_0000, BMRD_SEL_FLASH);
    remap_pulse(0);
    chk({3'h0, remap}, 4'h0);
    pick(32'h0, BMRD_SEL_ROM, 32'h0, BMRD_SEL_ROM);
    // set and clear in one cycle: set wins
    @(posedge mclk);
    #2 {rs, rc} = 2'b11;
    @(posedge mclk);
    #2 {rs, rc} = 2'b00;
    chk({3'h0, remap}, 4'h1);
    $display("test remap done");
  endtask
  task automatic t_flash_boot();
    do_reset(1, 0);
    chk({3'h0, bss}, 4'h1);
    chk({3'h0, remap}, 4'h0);
    pick(32'h0, BMRD_SEL_FLASH, 32'h0fff_fffc, BMRD_SEL_FLASH);
    remap_pulse(1);
    pick(32'h0, BMRD_SEL_SRAM, 32'h0, BMRD_SEL_SRAM);
    do_reset(1, 1); // erase lands before the strap is taken
    chk({3'h0, bss}, 4'h0);
    pick(32'h0, BMRD_SEL_ROM, 32'h0, BMRD_SEL_ROM);
    $display("test flash_boot done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    $display("unexpected at %0t: run too long", $time);
    results();
  end
  initial begin
    do_reset(0, 0);
    t_rom_boot();
    t_own_bases();
    t_late_strap();
    t_remap();
    t_flash_boot();
    results();
  end
endmodule
